// ---- logic/vic_pkg.sv ----
// constants for the vectored interrupt controller
package vic_pkg;
   localparam int NSRC  = 72;                     // request numbers 0..71, seven of them reserved
   localparam int NFLAG = 5;                      // flag and enable words
   localparam int NPRI  = 18;                     // priority words
   localparam int FW    = NFLAG * 16;             // flag storage width
   localparam int NEXT  = 5;                      // external request pins
   localparam int NTRAP = 5;                      // trap sources
   // word indices, byte address is four times the index
   localparam logic [5:0] IDX_GC1   = 6'h00;
   localparam logic [5:0] IDX_GC2   = 6'h01;
   localparam logic [5:0] IDX_FLAG0 = 6'h02;
   localparam logic [5:0] IDX_EN0   = 6'h07;
   localparam logic [5:0] IDX_PRI0  = 6'h0C;
   localparam logic [5:0] IDX_PEND  = 6'h1E;
   localparam logic [5:0] IDX_CPUSR = 6'h1F;
   localparam logic [5:0] IDX_CORE  = 6'h20;
   // field positions and writable masks
   localparam int NEST_BIT = 15;                  // global_control_one nesting_disable
   localparam int TRAP_LSB = 1;                   // trap status bits 5:1 of global_control_one
   localparam logic [15:0] GC1_MASK = 16'hFFFE;
   localparam int ALT_BIT  = 15;                  // global_control_two alt_table_select
   localparam logic [15:0] GC2_MASK = 16'h801F;
   localparam int IPL_LSB  = 5;                   // cpu_status_reg bits 7:5
   localparam int TOP_BIT  = 3;                   // core_control_reg bit 3
   localparam int PEND_LVL_LSB = 8;               // pending_level at bits 11:8
   // vector numbering and table layout
   localparam logic [6:0]  VEC_IRQ_BASE = 7'h08;  // vector = request number + 8
   localparam logic [23:0] VT_BASE      = 24'h000004;
   localparam logic [23:0] ALT_OFS      = 24'h000100;
   localparam logic [23:0] CODE_START   = 24'h000200;
   localparam logic [3:0]  TRAP_LVL_TOP = 4'hF;   // trap k takes level 15 - k
   // request numbers of external_request_zero..four
   localparam int EXT_NUM [NEXT] = '{0, 20, 29, 53, 54};
   // implemented request numbers; 72 and above never raised
   localparam logic [FW-1:0] IMPL_MASK = 80'h00F7_A7FF_DFFF_FFFB_7FFF;
endpackage

// ---- logic/vic_top.sv ----
// vectored interrupt controller with avalon-mm register slave
// Function
// R1: request n gives vector n+8, table address
// R2: five traps ordered, vectors 1 to 5
// R3: only requests 0..71 exist, rest never raised
// R4: alternate table laid out like primary, offset 0x100
// R5: thirty controller registers on the bus; the code maps thirty-three
// R6: hardware sets flags, only software clears them
// R7: a flag requests only when enabled
// R8: three-bit priority per user source
// R9: pending register holds vector and its level
// R10: fields allocated in request-number order
// R11: software writes cpu level in status bits 7:5
// R12: top cpu level bit is read-only
// R13: level is top bit joined to lower three
// R14: top bit set blocks every user source
// R15: nesting disable makes level bits read-only
// R16: control two holds polarities and table select
// R17: table select picks alternate vectors for all
// R18: equal priority, lower request number wins
// R19: table entries are 24-bit routine addresses
// R20: request only above cpu level, highest wins
`timescale 1ns/100ps
`default_nettype none
module vic_top (
   // clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_n_i,
   // avalon-mm slave
   input  wire logic [7:0]  avs_address_i,
   input  wire logic        avs_read_i,
   input  wire logic        avs_write_i,
   input  wire logic [31:0] avs_writedata_i,
   input  wire logic [3:0]  avs_byteenable_i,
   output logic      [31:0] avs_readdata_o,
   output logic             avs_waitrequest_o,
   // request sources
   input  wire logic [71:0] src_event_i,
   input  wire logic [4:0]  ext_pin_i,
   input  wire logic [4:0]  trap_event_i,
   // cpu core side
   input  wire logic        cpu_ipl_load_i,
   input  wire logic [3:0]  cpu_ipl_i,
   output logic             irq_req_o,
   output logic      [6:0]  irq_vector_o,
   output logic      [3:0]  irq_level_o,
   output logic      [23:0] irq_addr_o,
   output logic      [3:0]  cpu_ipl_o
);
   // byte-lane merge of a 16-bit register
   function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] wd,
                                           input logic [1:0] be);
      merge16 = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
   endfunction

   // vector table word address of a vector
   function automatic logic [23:0] vec_addr(input logic [6:0] vec, input logic alt);
      vec_addr = vic_pkg::VT_BASE + {16'h0000, vec, 1'b0} + (alt ? vic_pkg::ALT_OFS : 24'h000000);
   endfunction

   // bus state
   logic                  acc_ff;           // high in the accepting cycle
   logic [31:0]           rdata_ff;         // read data, stands at accept edge
   logic [5:0]            widx;             // word index of access
   logic [15:0]           wd16;             // low half of write data
   logic [1:0]            be2;              // lanes of low half
   logic                  wr_acc;           // write takes effect this edge
   logic [15:0]           rd16;             // read mux

   // controller state
   logic [15:0]           gc1_ff;           // global_control_one
   logic [15:0]           gc2_ff;           // global_control_two
   logic [vic_pkg::FW-1:0] flag_ff;         // request_flag_reg words
   logic [vic_pkg::FW-1:0] en_ff;           // request_enable_reg words
   logic [2:0]            pri_ff [vic_pkg::NSRC];  // source_priority_reg fields
   logic [2:0]            ipl_lo_ff;        // cpu_priority_level bits 2:0
   logic                  ipl_top_ff;       // cpu_priority_top_bit
   logic [6:0]            pend_vec_ff;      // pending_vector_number
   logic [3:0]            pend_lvl_ff;      // pending_level
   logic                  req_ff;           // request to cpu
   logic [23:0]           addr_ff;          // vector fetch address

   // external pin synchronisers and edge state
   logic [4:0]            ext_s1_ff;        // first stage, read only by second
   logic [4:0]            ext_s2_ff;
   logic [4:0]            ext_d_ff;         // previous synced level

   // combinational values
   logic [vic_pkg::FW-1:0] set_v;           // hardware set pulses
   logic [vic_pkg::FW-1:0] nxt_flag;
   logic [4:0]            trap_set;
   logic [3:0]            cpu_ipl;
   logic                  nxt_req;
   logic [6:0]            nxt_vec;
   logic [3:0]            nxt_lvl;

   assign widx   = avs_address_i[7:2];
   assign wd16   = avs_writedata_i[15:0];
   assign be2    = avs_byteenable_i[1:0];
   assign wr_acc = avs_write_i & acc_ff;
   assign cpu_ipl = {ipl_top_ff, ipl_lo_ff};  // R13

   // one wait cycle per access, then accept
   assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~acc_ff;
   assign avs_readdata_o    = rdata_ff;

   // accept toggles so back-to-back requests each wait once
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         acc_ff <= 1'b0;
      end else begin
         acc_ff <= (avs_read_i | avs_write_i) & ~acc_ff;
      end
   end

   // read mux; unmapped words and reserved bits read zero, except global_control_one bits 14:6 and reserved-request priority fields
   always_comb begin
      rd16 = 16'h0000;
      if (widx == vic_pkg::IDX_GC1) begin  // R5
         rd16 = gc1_ff;
      end else if (widx == vic_pkg::IDX_GC2) begin
         rd16 = gc2_ff;
      end else if (widx == vic_pkg::IDX_PEND) begin
         rd16[6:0] = pend_vec_ff;  // R9
         rd16[vic_pkg::PEND_LVL_LSB +: 4] = pend_lvl_ff;
      end else if (widx == vic_pkg::IDX_CPUSR) begin
         rd16[vic_pkg::IPL_LSB +: 3] = ipl_lo_ff;
      end else if (widx == vic_pkg::IDX_CORE) begin
         rd16[vic_pkg::TOP_BIT] = ipl_top_ff;
      end
      for (int k = 0; k < vic_pkg::NFLAG; k++) begin
         if (widx == 6'(vic_pkg::IDX_FLAG0 + k)) begin
            rd16 = flag_ff[k*16 +: 16];
         end
         if (widx == 6'(vic_pkg::IDX_EN0 + k)) begin
            rd16 = en_ff[k*16 +: 16];
         end
      end
      for (int j = 0; j < vic_pkg::NPRI; j++) begin
         if (widx == 6'(vic_pkg::IDX_PRI0 + j)) begin
            for (int i = 0; i < 4; i++) begin
               rd16[i*4 +: 3] = pri_ff[j*4 + i];  // R10
            end
         end
      end
   end

   // read data captured in the wait cycle
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rdata_ff <= 32'h0000_0000;
      end else if (avs_read_i && !acc_ff) begin
         rdata_ff <= {16'h0000, rd16};
      end
   end

   // external pins: two flops before any logic looks
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ext_s1_ff <= 5'h00;
         ext_s2_ff <= 5'h00;
         ext_d_ff  <= 5'h00;
      end else begin
         ext_s1_ff <= ext_pin_i;
         ext_s2_ff <= ext_s1_ff;
         ext_d_ff  <= ext_s2_ff;
      end
   end

   // hardware set pulses; polarity bit high picks falling edge
   always_comb begin
      set_v = '0;
      set_v[vic_pkg::NSRC-1:0] = src_event_i;
      for (int e = 0; e < vic_pkg::NEXT; e++) begin
         set_v[vic_pkg::EXT_NUM[e]] = gc2_ff[e] ? (ext_d_ff[e] & ~ext_s2_ff[e])   // R16
                                                : (ext_s2_ff[e] & ~ext_d_ff[e]);
      end
      set_v = set_v & vic_pkg::IMPL_MASK;  // R3
   end

   // flags: software write, then hardware set wins over a clear
   always_comb begin
      nxt_flag = flag_ff;
      for (int k = 0; k < vic_pkg::NFLAG; k++) begin
         if (wr_acc && widx == 6'(vic_pkg::IDX_FLAG0 + k)) begin
            nxt_flag[k*16 +: 16] = merge16(flag_ff[k*16 +: 16], wd16, be2);  // R10
         end
      end
      nxt_flag = (nxt_flag | set_v) & vic_pkg::IMPL_MASK;  // R6
   end

   // flag storage, never cleared by hardware itself
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         flag_ff <= '0;
      end else begin
         flag_ff <= nxt_flag;  // R6
      end
   end

   // enable storage, reserved requests hold zero
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         en_ff <= '0;
      end else begin
         for (int k = 0; k < vic_pkg::NFLAG; k++) begin
            if (wr_acc && widx == 6'(vic_pkg::IDX_EN0 + k)) begin
               en_ff[k*16 +: 16] <= merge16(en_ff[k*16 +: 16], wd16, be2) & vic_pkg::IMPL_MASK[k*16 +: 16];
            end
         end
      end
   end

   // priority fields, four sources per word at bits 2:0, 6:4, 10:8, 14:12
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         for (int n = 0; n < vic_pkg::NSRC; n++) begin
            pri_ff[n] <= 3'h0;
         end
      end else begin
         for (int j = 0; j < vic_pkg::NPRI; j++) begin
            for (int i = 0; i < 4; i++) begin
               if (wr_acc && widx == 6'(vic_pkg::IDX_PRI0 + j) && be2[i/2]) begin
                  pri_ff[j*4 + i] <= wd16[i*4 +: 3];  // R8
               end
            end
         end
      end
   end

   // trap status bits set by hardware, set wins over software clear
   always_comb begin
      trap_set = trap_event_i;
   end

   // global_control_one: nesting disable and trap flags
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         gc1_ff <= 16'h0000;
      end else if (wr_acc && widx == vic_pkg::IDX_GC1) begin
         gc1_ff <= (merge16(gc1_ff, wd16, be2) & vic_pkg::GC1_MASK)
                   | {10'h000, trap_set, 1'b0};  // R6
      end else begin
         gc1_ff <= gc1_ff | {10'h000, trap_set, 1'b0};
      end
   end

   // global_control_two: edge polarities and table select
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         gc2_ff <= 16'h0000;
      end else if (wr_acc && widx == vic_pkg::IDX_GC2) begin
         gc2_ff <= merge16(gc2_ff, wd16, be2) & vic_pkg::GC2_MASK;  // R16
      end
   end

   // cpu level: core load beats a software write in the same cycle
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ipl_lo_ff  <= 3'h0;
         ipl_top_ff <= 1'b0;
      end else if (cpu_ipl_load_i) begin
         ipl_lo_ff  <= cpu_ipl_i[2:0];
         ipl_top_ff <= cpu_ipl_i[3];  // R12
      end else if (wr_acc && widx == vic_pkg::IDX_CPUSR && be2[0]
                   && !gc1_ff[vic_pkg::NEST_BIT]) begin  // R15
         ipl_lo_ff  <= wd16[vic_pkg::IPL_LSB +: 3];  // R11
      end
   end

   // arbitration: traps first in natural order, then user sources
   always_comb begin
      logic [2:0] best_p;
      best_p  = ipl_lo_ff;  // R20
      nxt_req = 1'b0;
      nxt_vec = 7'h00;
      nxt_lvl = 4'h0;
      // user sources; strict compare keeps the lower number on ties
      for (int n = 0; n < vic_pkg::NSRC; n++) begin
         if (flag_ff[n] && en_ff[n] && !ipl_top_ff && pri_ff[n] > best_p) begin  // R7 R14 R18
            best_p  = pri_ff[n];
            nxt_req = 1'b1;
            nxt_vec = vic_pkg::VEC_IRQ_BASE + 7'(n);  // R1
            nxt_lvl = {1'b0, pri_ff[n]};  // R9
         end
      end
      // traps are not maskable by software; loop runs low index last
      for (int t = vic_pkg::NTRAP - 1; t >= 0; t--) begin
         if (gc1_ff[vic_pkg::TRAP_LSB + t]
             && (vic_pkg::TRAP_LVL_TOP - 4'(t + 1)) > cpu_ipl) begin  // R2
            nxt_req = 1'b1;
            nxt_vec = 7'(t + 1);
            nxt_lvl = vic_pkg::TRAP_LVL_TOP - 4'(t + 1);
         end
      end
   end

   // pending register and request outputs; request latched every cycle, the rest only when nxt_req
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         req_ff      <= 1'b0;
         pend_vec_ff <= 7'h00;
         pend_lvl_ff <= 4'h0;
         addr_ff     <= 24'h000000;
      end else begin
         req_ff <= nxt_req;
         if (nxt_req) begin
            pend_vec_ff <= nxt_vec;  // R9
            pend_lvl_ff <= nxt_lvl;
            addr_ff     <= vec_addr(nxt_vec, gc2_ff[vic_pkg::ALT_BIT]);  // R17 R4 R19
         end
      end
   end

   // outputs to the core
   assign irq_req_o    = req_ff;
   assign irq_vector_o = pend_vec_ff;
   assign irq_level_o  = pend_lvl_ff;
   assign irq_addr_o   = addr_ff;
   assign cpu_ipl_o    = cpu_ipl;  // R13
endmodule
`default_nettype wire

// ---- bench/vic_props.sv ----
// port checker for the vectored interrupt controller
`timescale 1ns/100ps
`default_nettype none
module vic_props (
   // clock and reset
   input wire logic        clk_i,
   input wire logic        rst_n_i,
   // register bus
   input wire logic [7:0]  avs_address_i,
   input wire logic        avs_read_i,
   input wire logic        avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0]  avs_byteenable_i,
   input wire logic [31:0] avs_readdata_o,
   input wire logic        avs_waitrequest_o,
   // sources
   input wire logic [71:0] src_event_i,
   input wire logic [4:0]  ext_pin_i,
   input wire logic [4:0]  trap_event_i,
   // core side
   input wire logic        cpu_ipl_load_i,
   input wire logic [3:0]  cpu_ipl_i,
   input wire logic        irq_req_o,
   input wire logic [6:0]  irq_vector_o,
   input wire logic [3:0]  irq_level_o,
   input wire logic [23:0] irq_addr_o,
   input wire logic [3:0]  cpu_ipl_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   logic bus_rq;                          // any access in progress
   assign bus_rq = avs_read_i | avs_write_i;
   a_wait_first: assert property ($rose(bus_rq) |-> avs_waitrequest_o)
      else $error("access started without a wait cycle");
   a_wait_once: assert property (bus_rq && avs_waitrequest_o |=> !avs_waitrequest_o)
      else $error("wait cycle longer than one");
   a_read_upper: assert property (avs_read_i && !avs_waitrequest_o |-> avs_readdata_o[31:16] == 16'h0000)
      else $error("read data upper half not zero");
   // table offset is two words per vector, alternate adds one page
   a_addr_table: assert property (irq_req_o |-> irq_addr_o[7:0] == 8'h04 + {irq_vector_o, 1'b0}
      && irq_addr_o[23:9] == 15'h0000)
      else $error("vector address wrong");
   a_trap_order: assert property (irq_req_o && irq_vector_o < 7'h08 |-> irq_vector_o inside {[1:5]}
      && irq_level_o == 4'hF - irq_vector_o[3:0])
      else $error("trap vector or level wrong");
   a_user_range: assert property (irq_req_o && irq_vector_o >= 7'h08 |-> irq_vector_o <= 7'h4F
      && !irq_level_o[3])
      else $error("user vector or level out of range");
   a_top_blocks: assert property (irq_req_o && cpu_ipl_o[3] && $past(cpu_ipl_o[3]) |-> irq_vector_o < 7'h08)
      else $error("user source taken with top level bit set");
   a_above_level: assert property (irq_req_o && $stable(cpu_ipl_o) |-> irq_level_o > cpu_ipl_o)
      else $error("request not above cpu level");
   a_level_load: assert property (cpu_ipl_load_i |=> cpu_ipl_o == $past(cpu_ipl_i))
      else $error("cpu level not loaded");
   c_trap: cover property (irq_req_o && irq_vector_o == 7'h01);
   c_alt: cover property (irq_req_o && irq_addr_o[8]);
   c_load: cover property (cpu_ipl_load_i && irq_req_o);
endmodule
bind vic_top vic_props u_props (.clk_i, .rst_n_i, .avs_address_i, .avs_read_i, .avs_write_i,
   .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o, .src_event_i,
   .ext_pin_i, .trap_event_i, .cpu_ipl_load_i, .cpu_ipl_i, .irq_req_o, .irq_vector_o,
   .irq_level_o, .irq_addr_o, .cpu_ipl_o);
`default_nettype wire

// ---- bench/vic_cpu_model.sv ----
// processor core model that takes vectored requests
`timescale 1ns/100ps
`default_nettype none
module vic_cpu_model (
   // clock and reset
   input  wire logic       clk_i,
   input  wire logic       rst_n_i,
   // controller side
   input  wire logic       irq_req_i,
   input  wire logic [3:0] irq_level_i,
   output logic            cpu_ipl_load_o,
   output logic      [3:0] cpu_ipl_o,
   // bench control
   input  wire logic       take_en_i,
   input  wire logic [3:0] wait_i,
   input  wire logic       set_i,
   input  wire logic [3:0] set_lvl_i
);
   logic [3:0] wait_ff;                    // answer delay count
   // restart after each load, else a stale request is taken twice
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wait_ff <= 4'h0;
      end else if (cpu_ipl_load_o || !irq_req_i) begin
         wait_ff <= 4'h0;
      end else if (take_en_i && wait_ff != 4'hF) begin
         wait_ff <= wait_ff + 4'h1;
      end
   end
   // level load: a forced level beats taking a request
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cpu_ipl_load_o <= 1'b0;
         cpu_ipl_o      <= 4'h0;
      end else if (set_i) begin
         cpu_ipl_load_o <= 1'b1;
         cpu_ipl_o      <= set_lvl_i;
      end else if (take_en_i && irq_req_i && wait_ff >= wait_i && !cpu_ipl_load_o) begin
         cpu_ipl_load_o <= 1'b1;
         cpu_ipl_o      <= irq_level_i;
      end else begin
         cpu_ipl_load_o <= 1'b0;
      end
   end
endmodule
`default_nettype wire

// ---- bench/testbench.sv ----
// self-checking bench for the vectored interrupt controller
`timescale 1ns/100ps
`default_nettype none
module testbench;
   logic        clk_i = 1'b0;             // 125 MHz clock
   logic        rst_n_i = 1'b0;           // asynchronous reset
   logic [7:0]  adr = 8'h00;              // bus request
   logic        rd = 1'b0;
   logic        wr = 1'b0;
   logic [31:0] wdat = 32'h0;
   logic [31:0] rdat;
   logic        wreq;
   logic [31:0] r;                        // last read value
   logic [71:0] src = '0;                 // peripheral events
   logic [4:0]  trap = 5'h00;
   logic [4:0]  ext = 5'h00;              // external request pins
   logic        ld;                       // core side
   logic        req;
   logic        tk = 1'b0;
   logic        st = 1'b0;
   logic [3:0]  lvl_in;
   logic [3:0]  lvl;
   logic [3:0]  cpu_priority_level;
   logic [3:0]  slv = 4'h0;
   logic [6:0]  vec;
   logic [23:0] vad;
   int          error_cnt = 0;
   int          n_tests = 0;
   always #4 clk_i = ~clk_i;
   vic_top dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr),
      .avs_writedata_i(wdat), .avs_byteenable_i(4'hF), .avs_readdata_o(rdat), .avs_waitrequest_o(wreq),
      .src_event_i(src), .ext_pin_i(ext), .trap_event_i(trap), .cpu_ipl_load_i(ld), .cpu_ipl_i(lvl_in),
      .irq_req_o(req), .irq_vector_o(vec), .irq_level_o(lvl), .irq_addr_o(vad), .cpu_ipl_o(cpu_priority_level));
   vic_cpu_model core (.clk_i(clk_i), .rst_n_i(rst_n_i), .irq_req_i(req), .irq_level_i(lvl),
      .cpu_ipl_load_o(ld), .cpu_ipl_o(lvl_in), .take_en_i(tk), .wait_i(4'h3), .set_i(st), .set_lvl_i(slv));
   // compare and count
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // one bus access, held until waitrequest is seen low
   task automatic bus(input logic w, input logic [5:0] i, input logic [15:0] d);
      int k;
      k = 0;
      @(posedge clk_i);
      adr <= {i, 2'b00};
      wdat <= {16'h0000, d};
      wr <= w;
      rd <= !w;
      do begin
         @(posedge clk_i);
         k++;
      end while (wreq !== 1'b0 && k < 20);
      r = rdat;
      wr <= 1'b0;
      rd <= 1'b0;
      if (k >= 20) begin
         error_cnt++;
         tally_and_finish();
      end
   endtask
   task automatic rdc(input string nm, input logic [5:0] i, input logic [15:0] e);
      bus(1'b0, i, 16'h0000);
      chk(nm, {16'h0000, e}, r);
   endtask
   // let the request outputs follow the registered state
   task automatic irqc(input logic q, input logic [6:0] v, input logic [3:0] l, input logic [23:0] a);
      repeat (2) @(posedge clk_i);
      @(negedge clk_i);
      chk("irq_req", q, req);
      if (q) begin
         chk("irq_vector", v, vec);
         chk("irq_level", l, lvl);
         chk("irq_addr", a, vad);
      end
   endtask
   // forced cpu level through the core model
   task automatic setl(input logic [3:0] l);
      @(posedge clk_i);
      st <= 1'b1;
      slv <= l;
      @(posedge clk_i);
      st <= 1'b0;
   endtask
   task automatic t_reset;
      logic [5:0] idx [6] = '{6'h00, 6'h01, 6'h1E, 6'h1F, 6'h20, 6'h3F};
      foreach (idx[j]) rdc("reset value", idx[j], 16'h0000);
      irqc(1'b0, 7'h00, 4'h0, 24'h0);
      $display("test reset done");
   endtask
   task automatic t_arb;
      bus(1'b1, vic_pkg::IDX_PRI0, 16'h7550);
      bus(1'b1, vic_pkg::IDX_EN0, 16'h0006);
      @(posedge clk_i);
      src[3:1] <= 3'h7;
      @(posedge clk_i);
      src[3:1] <= 3'h0;
      irqc(1'b1, 7'h09, 4'h5, 24'h000016);
      rdc("pending", vic_pkg::IDX_PEND, 16'h0509);
      rdc("flags", vic_pkg::IDX_FLAG0, 16'h000E);
      bus(1'b1, vic_pkg::IDX_EN0, 16'h000E);
      irqc(1'b1, 7'h0B, 4'h7, 24'h00001A);
      bus(1'b1, vic_pkg::IDX_GC2, 16'h8000);
      irqc(1'b1, 7'h0B, 4'h7, 24'h00011A);
      bus(1'b1, vic_pkg::IDX_GC2, 16'h0000);
      $display("test arbitration done");
   endtask
   task automatic t_level;
      bus(1'b1, vic_pkg::IDX_CPUSR, 16'h00C0);
      irqc(1'b1, 7'h0B, 4'h7, 24'h00001A);
      bus(1'b1, vic_pkg::IDX_CPUSR, 16'h00E0);
      irqc(1'b0, 7'h00, 4'h0, 24'h0);
      rdc("cpu status", vic_pkg::IDX_CPUSR, 16'h00E0);
      bus(1'b1, vic_pkg::IDX_GC1, 16'h8000);
      bus(1'b1, vic_pkg::IDX_CPUSR, 16'h0000);
      rdc("locked level", vic_pkg::IDX_CPUSR, 16'h00E0);
      bus(1'b1, vic_pkg::IDX_GC1, 16'h0000);
      bus(1'b1, vic_pkg::IDX_CPUSR, 16'h0000);
      bus(1'b1, vic_pkg::IDX_CORE, 16'h0008);
      rdc("core control", vic_pkg::IDX_CORE, 16'h0000);
      chk("cpu level", 32'h0, {28'h0, cpu_priority_level});
      $display("test cpu level done");
   endtask
   task automatic t_trap;
      setl(4'h8);
      irqc(1'b0, 7'h00, 4'h0, 24'h0);
      @(posedge clk_i);
      trap <= 5'h03;
      @(posedge clk_i);
      trap <= 5'h00;
      irqc(1'b1, 7'h01, 4'hE, 24'h000006);
      rdc("trap flags", vic_pkg::IDX_GC1, 16'h0006);
      bus(1'b1, vic_pkg::IDX_GC1, 16'h0000);
      irqc(1'b0, 7'h00, 4'h0, 24'h0);
      setl(4'h0);
      $display("test traps done");
   endtask
   task automatic t_ack;
      int k;
      @(posedge clk_i);
      tk <= 1'b1;
      for (k = 0; k < 40 && cpu_priority_level !== 4'h7; k++) @(posedge clk_i);
      tk <= 1'b0;
      if (k >= 40) begin
         error_cnt++;
         tally_and_finish();
      end
      irqc(1'b0, 7'h00, 4'h0, 24'h0);
      chk("taken level", 32'h7, {28'h0, cpu_priority_level});
      rdc("flags kept", vic_pkg::IDX_FLAG0, 16'h000E);
      bus(1'b1, vic_pkg::IDX_FLAG0, 16'h0000);
      rdc("flags cleared", vic_pkg::IDX_FLAG0, 16'h0000);
      setl(4'h0);
      $display("test core take done");
   endtask
   task automatic t_resv;
      bus(1'b1, vic_pkg::IDX_FLAG0 + 6'h04, 16'hFFFF);
      rdc("top flags", vic_pkg::IDX_FLAG0 + 6'h04, 16'h00F7);
      bus(1'b1, vic_pkg::IDX_EN0 + 6'h04, 16'hFFFF);
      rdc("top enables", vic_pkg::IDX_EN0 + 6'h04, 16'h00F7);
      bus(1'b1, vic_pkg::IDX_FLAG0 + 6'h04, 16'h0000);
      $display("test reserved done");
   endtask
   // external pin zero, rising edge first, then falling polarity
   task automatic t_ext;
      bus(1'b1, vic_pkg::IDX_PRI0, 16'h0003);
      bus(1'b1, vic_pkg::IDX_EN0, 16'h0001);
      @(posedge clk_i);
      ext[0] <= 1'b1;
      repeat (2) @(posedge clk_i);
      irqc(1'b1, 7'h08, 4'h3, 24'h000014);
      rdc("rising pin flag", vic_pkg::IDX_FLAG0, 16'h0001);
      bus(1'b1, vic_pkg::IDX_FLAG0, 16'h0000);
      bus(1'b1, vic_pkg::IDX_GC2, 16'h0001);
      irqc(1'b0, 7'h00, 4'h0, 24'h0);
      @(posedge clk_i);
      ext[0] <= 1'b0;
      repeat (2) @(posedge clk_i);
      irqc(1'b1, 7'h08, 4'h3, 24'h000014);
      rdc("falling pin flag", vic_pkg::IDX_FLAG0, 16'h0001);
      bus(1'b1, vic_pkg::IDX_FLAG0, 16'h0000);
      bus(1'b1, vic_pkg::IDX_GC2, 16'h0000);
      bus(1'b1, vic_pkg::IDX_EN0, 16'h0000);
      $display("test external pins done");
   endtask
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   // main sequence
   initial begin
      repeat (3) @(posedge clk_i);
      rst_n_i <= 1'b1;
      t_reset();
      t_arb();
      t_level();
      t_trap();
      t_ack();
      t_resv();
      t_ext();
      tally_and_finish();
   end
endmodule
`default_nettype wire
